/* File: verilog/rpc_pkg.sv */
// Package for the receive per-channel control block.
// Assumes a single 250 MHz clock and an 8-bit register port.
`default_nettype none
package rpc_pkg;
	// Register offsets and reset values on the host port
	localparam logic [7:0] RPC_CFG_ADDR = 8'h50;
	localparam logic [7:0] RPC_STATUS_ADDR = 8'h51;
	localparam logic [7:0] RPC_ADDR_CTRL_ADDR = 8'h52;
	localparam logic [7:0] RPC_DATA_BUF_ADDR = 8'h53;
	localparam logic [7:0] RPC_DATA_BUF_RESET = 8'h00;
	localparam logic [7:0] RPC_ADDR_CTRL_RESET = 8'h00;
	// Address/control, config and status fields
	localparam int RPC_DIR_BIT = 7;
	localparam int RPC_CFG_IND_BIT = 1;
	localparam int RPC_CFG_EN_BIT = 0;
	localparam int RPC_BUSY_BIT = 7;
	// Internal table index bands
	localparam logic [6:0] RPC_CTRL_FIRST = 7'h01;
	localparam logic [6:0] RPC_CTRL_LAST = 7'h18;
	localparam logic [6:0] RPC_DTRK_FIRST = 7'h19;
	localparam logic [6:0] RPC_DTRK_LAST = 7'h30;
	localparam logic [6:0] RPC_STRK_FIRST = 7'h31;
	localparam logic [6:0] RPC_STRK_LAST = 7'h48;
	// Control byte fields
	localparam int RPC_INVERT_BIT = 7;
	localparam int RPC_DTRK_SUB_BIT = 6;
	localparam int RPC_MW_BIT = 5;
	localparam int RPC_SIGN_INV_BIT = 4;
	// Access timing
	localparam int RPC_CLK_MHZ = 250;
	localparam int RPC_ACCESS_NS = 640;
	localparam int RPC_ACCESS_CYC = (RPC_ACCESS_NS * RPC_CLK_MHZ) / 1000;
	localparam int RPC_CNT_W = 8;
	// Access machine states
	typedef enum logic [1:0] {
		RPC_IDLE = 2'b00,
		RPC_RUN = 2'b01,
		RPC_DONE = 2'b10
	} rpc_state_t;
endpackage : rpc_pkg
`default_nettype wire

/* File: verilog/rpc_pcm_modify.sv */
// Per-bit modifier for the receive PCM output stream.
// Assumes bit_pos counts 7 down to 0 across a timeslot, MSB first.
`default_nettype none
module rpc_pcm_modify
	import rpc_pkg::*;
(
	input wire logic [7:0] ctrl_byte,
	input wire logic [7:0] dtrk_byte,
	input wire logic [7:0] mw_byte,
	input wire logic [2:0] bit_pos,
	input wire logic rx_bit,
	input wire logic enable,
	output logic out_bit
);
	logic inv;
	// Priority: milliwatt, trunk substitution, inversions
	always_comb begin
		inv = ctrl_byte[RPC_INVERT_BIT];
		if (bit_pos == 3'h7)
			inv = inv ^ ctrl_byte[RPC_SIGN_INV_BIT];
		if (!enable)
			out_bit = rx_bit;
		else if (ctrl_byte[RPC_MW_BIT])
			out_bit = mw_byte[bit_pos];
		else if (ctrl_byte[RPC_DTRK_SUB_BIT])
			out_bit = dtrk_byte[bit_pos];
		else
			out_bit = rx_bit ^ inv;
	end
endmodule : rpc_pcm_modify
`default_nettype wire

/* File: verilog/rpc_receive_per_channel_ctrl.sv */
// Indirect access path and per-channel table for receive PCM control.
// Assumes a host port with one-cycle strobes and read data a cycle later,
// and a receive stream with channel number and bit position supplied.
//
// The implementer's own choice: the address-and-strobe port.
`default_nettype none
// How it works
// - Data buffer holds write byte, and read result after an internal read.
// - Read result lands in the data buffer within 640 ns.
// - Indices 01h-18h are control bytes for channels 1 to 24.
// - Indices 19h-30h are data trunk bytes for channels 1 to 24.
// - Indices 31h-48h are signalling trunk bytes for channels 1 to 24.
// - Control byte: invert bit7, trunk bit6, milliwatt bit5, sign bit4.
// - Invert flag complements every output bit of that channel, except bit 7 when the sign bit is also set.
// - Table drives per-channel output processing and conditioning codes.
// - Busy is high during an access, drops on a clock edge after.
// - Address/control write while idle starts access; bits 6:0 index, bit7 read.
// - Trunk flag replaces the whole timeslot with the trunk byte.
// - Milliwatt beats trunk substitution, which beats inversion.
module rpc_receive_per_channel_ctrl
	import rpc_pkg::*;
#(
	parameter int NUM_CH = 24,
	parameter int ACCESS_CYC = RPC_ACCESS_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rx_pcm_in,
	input wire logic [4:0] rx_channel,
	input wire logic [2:0] rx_bit_pos,
	input wire logic [7:0] milliwatt_byte,
	output logic receive_pcm_out,
	output logic [4:0] sig_trunk_code,
	output logic sig_trunk_sub
);
	logic [7:0] ctrl_mem [NUM_CH];
	logic [7:0] dtrk_mem [NUM_CH];
	logic [7:0] strk_mem [NUM_CH];
	logic [7:0] data_buf_q, data_buf_d;
	logic [7:0] addr_ctrl_q, addr_ctrl_d;
	logic [1:0] cfg_q, cfg_d;
	logic [7:0] rdata_q, rdata_d;
	logic [RPC_CNT_W-1:0] cnt_q, cnt_d;
	rpc_state_t state_q, state_d;
	logic tbl_we;
	logic [7:0] tbl_rd;
	logic [6:0] idx;
	logic [4:0] ch_sel;
	logic [1:0] band;
	logic busy;
	logic pcm_d, pcm_q;
	logic [4:0] sig_code_d, sig_code_q;
	logic sig_sub_d, sig_sub_q;

	// Target index and busy flag from the held access
	assign idx = addr_ctrl_q[6:0];
	assign busy = (state_q != RPC_IDLE);

	// Decode table index into band and channel
	always_comb begin
		band = 2'h0;
		ch_sel = 5'h00;
		if (idx >= RPC_CTRL_FIRST && idx <= RPC_CTRL_LAST) begin
			band = 2'h1;
			ch_sel = 5'(idx - RPC_CTRL_FIRST);
		end else if (idx >= RPC_DTRK_FIRST && idx <= RPC_DTRK_LAST) begin
			band = 2'h2;
			ch_sel = 5'(idx - RPC_DTRK_FIRST);
		end else if (idx >= RPC_STRK_FIRST && idx <= RPC_STRK_LAST) begin
			band = 2'h3;
			ch_sel = 5'(idx - RPC_STRK_FIRST);
		end
	end

	// Table read mux
	always_comb begin
		case (band)
			2'h1: tbl_rd = ctrl_mem[ch_sel];
			2'h2: tbl_rd = dtrk_mem[ch_sel];
			2'h3: tbl_rd = strk_mem[ch_sel];
			default: tbl_rd = 8'h00;
		endcase
	end

	// Host registers and access machine next state
	always_comb begin
		data_buf_d = data_buf_q;
		addr_ctrl_d = addr_ctrl_q;
		cfg_d = cfg_q;
		state_d = state_q;
		cnt_d = cnt_q;
		tbl_we = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				RPC_CFG_ADDR: cfg_d = reg_wdata[1:0];
				RPC_DATA_BUF_ADDR: data_buf_d = reg_wdata;
				default: ;
			endcase
		end
		case (state_q)
			RPC_IDLE: begin
				if (reg_wr && reg_addr == RPC_ADDR_CTRL_ADDR) begin
					addr_ctrl_d = reg_wdata;
					state_d = RPC_RUN;
					cnt_d = RPC_CNT_W'(ACCESS_CYC - 2);
				end
			end
			RPC_RUN: begin
				if (cnt_q == '0) begin
					state_d = RPC_DONE;
					if (addr_ctrl_q[RPC_DIR_BIT])
						data_buf_d = tbl_rd;
					else
						tbl_we = (band != 2'h0);
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			RPC_DONE: state_d = RPC_IDLE;
			default: state_d = RPC_IDLE;
		endcase
	end

	// Register the host-side state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_buf_q <= RPC_DATA_BUF_RESET;
			addr_ctrl_q <= RPC_ADDR_CTRL_RESET;
			cfg_q <= 2'h0;
			state_q <= RPC_IDLE;
			cnt_q <= '0;
		end else begin
			data_buf_q <= data_buf_d;
			addr_ctrl_q <= addr_ctrl_d;
			cfg_q <= cfg_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Table storage, written at access completion
	always_ff @(posedge clk) begin
		if (tbl_we) begin
			case (band)
				2'h1: ctrl_mem[ch_sel] <= data_buf_q;
				2'h2: dtrk_mem[ch_sel] <= data_buf_q;
				default: strk_mem[ch_sel] <= data_buf_q;
			endcase
		end
	end

	// Read data mux, presented one cycle after the strobe
	always_comb begin
		rdata_d = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				RPC_CFG_ADDR: rdata_d = {6'h00, cfg_q};
				RPC_STATUS_ADDR: rdata_d = {busy, 7'h00};
				RPC_ADDR_CTRL_ADDR: rdata_d = addr_ctrl_q;
				RPC_DATA_BUF_ADDR: rdata_d = data_buf_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register, zero outside the answer cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			rdata_q <= 8'h00;
		else
			rdata_q <= rdata_d;
	end
	assign reg_rdata = rdata_q;

	// Channels beyond the table pass through untouched
	logic [4:0] ch_idx;
	logic en_pcm;
	assign ch_idx = (rx_channel < 5'(NUM_CH)) ? rx_channel : 5'h00;
	assign en_pcm = cfg_q[RPC_CFG_EN_BIT] && (rx_channel < 5'(NUM_CH));

	// Per-channel output processing from the table
	rpc_pcm_modify u_mod (
		.ctrl_byte(ctrl_mem[ch_idx]),
		.dtrk_byte(dtrk_mem[ch_idx]),
		.mw_byte(milliwatt_byte),
		.bit_pos(rx_bit_pos),
		.rx_bit(rx_pcm_in),
		.enable(en_pcm),
		.out_bit(pcm_d)
	);

	// Signalling code and substitution flag of the current channel
	always_comb begin
		sig_code_d = {strk_mem[ch_idx][7], strk_mem[ch_idx][3:0]};
		sig_sub_d = en_pcm && strk_mem[ch_idx][7];
	end

	// Registered output stream and signalling code
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcm_q <= 1'b0;
			sig_code_q <= 5'h00;
			sig_sub_q <= 1'b0;
		end else begin
			pcm_q <= pcm_d;
			sig_code_q <= sig_code_d;
			sig_sub_q <= sig_sub_d;
		end
	end

	// Outputs straight from their registers
	assign receive_pcm_out = pcm_q;
	assign sig_trunk_code = sig_code_q;
	assign sig_trunk_sub = sig_sub_q;
endmodule : rpc_receive_per_channel_ctrl
`default_nettype wire

/* File: test/rpc_properties.sv */
// Checker for the receive per-channel control block ports.
// Assumes it is bound onto every instance of the block.
`default_nettype none
module rpc_properties #(
	parameter int ACCESS_CYC = 160
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rx_pcm_in,
	input wire logic [4:0] rx_channel,
	input wire logic receive_pcm_out,
	input wire logic sig_trunk_sub
);
	logic [7:0] cnt_q, cnt_d;
	logic en_q, en_d;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Shadow of access time and enable bit
	always_comb begin
		cnt_d = cnt_q;
		en_d = (reg_wr && reg_addr == 8'h50) ? reg_wdata[0] : en_q;
		if (cnt_q != 8'h00)
			cnt_d = (cnt_q == 8'(ACCESS_CYC)) ? 8'h00 : cnt_q + 8'h01;
		else if (reg_wr && reg_addr == 8'h52)
			cnt_d = 8'h01;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			en_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			en_q <= en_d;
		end
	end
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero");
	a_busy_high: assert property (reg_rd && reg_addr == 8'h51 &&
		cnt_q != 8'h00 |=> reg_rdata == 8'h80) else $error("busy low");
	a_busy_low: assert property (reg_rd && reg_addr == 8'h51 &&
		cnt_q == 8'h00 |=> reg_rdata == 8'h00) else $error("busy high");
	a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h50 ||
		reg_addr > 8'h53) |=> reg_rdata == 8'h00) else $error("unmapped");
	a_buf_back: assert property (reg_wr && reg_addr == 8'h53 &&
		cnt_q == 8'h00 ##1 reg_rd && reg_addr == 8'h53 |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("buffer lost");
	a_ctrl_back: assert property (reg_wr && reg_addr == 8'h52 &&
		cnt_q == 8'h00 ##1 reg_rd && reg_addr == 8'h52 |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("addr lost");
	a_pass_thru: assert property (!$past(sys_rst) &&
		(!$past(en_q) || $past(rx_channel) > 5'd23) |->
		receive_pcm_out == $past(rx_pcm_in)) else $error("not passed");
	a_sig_off: assert property (!$past(sys_rst) && !$past(en_q)
		|-> !sig_trunk_sub) else $error("substitution while off");
endmodule : rpc_properties
bind rpc_receive_per_channel_ctrl rpc_properties #(
	.ACCESS_CYC(ACCESS_CYC)) rpc_properties_inst (.clk(clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.rx_pcm_in(rx_pcm_in), .rx_channel(rx_channel),
	.receive_pcm_out(receive_pcm_out), .sig_trunk_sub(sig_trunk_sub));
`default_nettype wire

/* File: test/rpc_host_model.sv */
// Host model making indirect table accesses on the register port.
// Assumes each task is entered just after a rising clock edge.
`default_nettype none
module rpc_host_model #(
	parameter int ACCESS_CYC = 4
) (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	int hang = 0;
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One write cycle; strobe stays up so writes can run back to back
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
	endtask : wr
	// Drop the write strobe, scramble data, let n edges pass
	task idle(input int n);
		reg_wr <= 1'b0;
		reg_wdata <= ~reg_wdata;
		repeat (n) @(posedge clk);
	endtask : idle
	// One read cycle, data taken at the edge ending the answer cycle
	task rd(input logic [7:0] a, output logic [7:0] d);
		reg_wr <= 1'b0;
		reg_wdata <= ~reg_wdata;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask : rd
	// Indirect access; writes poll busy, reads wait the access time
	task acc(input logic rw, input logic [6:0] idx, inout logic [7:0] d);
		logic [7:0] s;
		if (!rw)
			wr(8'h53, d);
		wr(8'h52, {rw, idx});
		if (rw) begin
			idle(ACCESS_CYC - 1);
			rd(8'h53, d);
		end else begin
			for (int i = 0; i < 50; i++) begin
				rd(8'h51, s);
				if (!s[7])
					break;
			end
			hang += int'(s[7]);
		end
	endtask : acc
endmodule : rpc_host_model
`default_nettype wire

/* File: test/test_rpc_receive_per_channel_ctrl.sv */
// Testbench for the receive per-channel control block.
// Assumes the host model drives the register port.
`default_nettype none
module test_rpc_receive_per_channel_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int AC = 4;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, x;
	logic [7:0] mw = 8'h00;
	logic [7:0] ctl [24], dtk [24], stk [24];
	logic reg_wr, reg_rd, pcm_out, sub, en;
	logic pcm_in = 1'b0;
	logic [4:0] ch = 5'h00;
	logic [4:0] code;
	logic [2:0] pos = 3'h0;
	int error_cnt = 0;
	int checked = 0;
	rpc_host_model #(.ACCESS_CYC(AC)) host (.clk(clk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	rpc_receive_per_channel_ctrl #(.NUM_CH(24), .ACCESS_CYC(AC))
		rpc_receive_per_channel_ctrl_inst (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pcm_in(pcm_in),
		.rx_channel(ch), .rx_bit_pos(pos), .milliwatt_byte(mw),
		.receive_pcm_out(pcm_out), .sig_trunk_code(code),
		.sig_trunk_sub(sub));
	task cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Expected output bit from the shadow table
	function automatic logic f(input logic [4:0] c, input logic [2:0] p,
		input logic b, input logic [7:0] m);
		if (!en || c > 5'd23)
			return b;
		if (ctl[c][5])
			return m[p];
		if (ctl[c][6])
			return dtk[c][p];
		return b ^ ctl[c][7] ^ (ctl[c][4] && p == 3'd7);
	endfunction : f
	// Random stream; outputs read at the second edge after each drive
	task stream(input int n);
		logic [4:0] c, k;
		logic [2:0] p;
		logic b;
		logic [7:0] m;
		logic [7:0] xp [2], xs [2], xc [2];
		for (int i = 0; i < n + 2; i++) begin
			@(posedge clk);
			if (i > 1) begin
				cmp(8'(pcm_out), xp[1]);
				cmp(8'(sub), xs[1]);
				cmp(8'(code), xc[1]);
			end
			c = 5'($urandom_range(25));
			p = 3'($urandom);
			b = 1'($urandom);
			m = 8'($urandom);
			k = (c < 24) ? c : 5'h00;
			xp[1] = xp[0];
			xs[1] = xs[0];
			xc[1] = xc[0];
			xp[0] = 8'(f(c, p, b, m));
			xs[0] = 8'(en && c < 24 && stk[k][7]);
			xc[0] = 8'({stk[k][7], stk[k][3:0]});
			ch <= c;
			pos <= p;
			pcm_in <= b;
			mw <= m;
		end
		$display("stream test done");
	endtask : stream
	task end_of_test;
		error_cnt += host.hang;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test
	// Free-running clock
	initial begin
		forever #2 clk = ~clk;
	end
	// Main sequence
	initial begin
		void'($urandom(79777));
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		for (int a = 8'h50; a < 8'h56; a++) begin
			host.rd(8'(a), d);
			cmp(d, 8'h00);
		end
		for (int i = 0; i < 24; i++) begin
			ctl[i] = 8'($urandom);
			dtk[i] = 8'($urandom);
			stk[i] = 8'($urandom) & 8'h8f;
			host.acc(1'b0, 7'(i + 1), ctl[i]);
			host.acc(1'b0, 7'(i + 25), dtk[i]);
			host.acc(1'b0, 7'(i + 49), stk[i]);
		end
		if (host.hang != 0)
			end_of_test();
		for (int i = 0; i < 72; i++) begin
			host.acc(1'b1, 7'(i + 1), d);
			x = i < 24 ? ctl[i] : i < 48 ? dtk[i - 24] : stk[i - 48];
			cmp(d, x);
		end
		$display("table test done");
		host.acc(1'b1, 7'h00, d);
		cmp(d, 8'h00);
		host.acc(1'b1, 7'h49, d);
		cmp(d, 8'h00);
		host.wr(8'h52, 8'h81);
		host.rd(8'h52, d);
		cmp(d, 8'h81);
		host.wr(8'h52, 8'h99);
		host.idle(AC);
		host.rd(8'h53, d);
		cmp(d, ctl[0]);
		host.rd(8'h52, d);
		cmp(d, 8'h81);
		host.wr(8'h53, 8'h5a);
		host.rd(8'h53, d);
		cmp(d, 8'h5a);
		$display("register test done");
		host.wr(8'h50, 8'h03);
		host.idle(1);
		en = 1'b1;
		stream(600);
		host.wr(8'h50, 8'h02);
		host.idle(1);
		en = 1'b0;
		stream(40);
		end_of_test();
	end
endmodule : test_rpc_receive_per_channel_ctrl
`default_nettype wire
